// *** verilog/sto_pkg.sv ***
// shared constants and types for the safe torque off gate
package sto_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  // input filter: off only after more than this low time
  localparam int FILT_MS = 2;
  localparam int FILT_CYC = FILT_MS * CLK_KHZ;
  // millisecond tick divider
  localparam int MS_CYC = CLK_KHZ;
  // disconnection alarm time
  localparam int DISC_S = 10;
  localparam int DISC_MS = DISC_S * 1000;
  // diagnostic intervals and their upper limits, in ms
  localparam int DIAG0_MS = 10;
  localparam int DIAG1_MS = 1000;
  localparam int DIAG0_LIM_MS = 20;
  localparam int DIAG1_LIM_MS = 3_600_000;
  // response and monitor limits, in ms
  localparam int RESP_MS = 30;
  localparam int MON_MS = 5;
  // cycles the gate command must be stable before readback counts
  localparam int SETTLE_CYC = 8;
  localparam int PWM_N = 6;
  // synchroniser lanes
  localparam int SY_ONE = 0;
  localparam int SY_TWO = 1;
  localparam int SY_FB = 2;
  localparam int SY_HFT = 3;
  localparam int SY_N = 4;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SAFE = 3'h2,
    ST_FAULT = 3'h4
  } sto_state_e;
endpackage

// *** verilog/sto_filt.sv ***
// glitch filter for one safety input channel
`timescale 1ns/1ps
module sto_filt
  import sto_pkg::*;
#(
  parameter int CYC = FILT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic raw,
  output logic on
);
  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic on;
  } sto_filt_s;

  sto_filt_s r_reg;
  sto_filt_s r_next;

  ////////////////////////////////////////////////////////////////////////
  // a change is accepted only after it held for more than CYC cycles;
  // the same filter applies to turning on so a bouncing contact
  // cannot release torque early
  always_comb begin
    r_next = r_reg;
    if (raw == r_reg.on) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == CW'(CYC)) begin
      r_next.cnt = '0;
      r_next.on = raw; // [RL4]
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  // reset to off: the channel is untrusted until it proves itself on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign on = r_reg.on;
endmodule

// *** verilog/sto_diag.sv ***
// periodic readback test of the gate blocking circuit
`timescale 1ns/1ps
module sto_diag
  import sto_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ms_tick,
  input wire logic hft_nonzero,
  input wire logic expect_en,
  input wire logic fb,
  output logic strobe,
  output logic fault
);
  localparam int IW = $clog2(DIAG1_MS + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    logic [IW-1:0] ms;
    logic [SW-1:0] settle;
    logic exp;
    logic strobe;
    logic fault;
  } sto_diag_s;

  sto_diag_s r_reg;
  sto_diag_s r_next;
  logic [IW-1:0] lim;

  ////////////////////////////////////////////////////////////////////////
  // test period: short without fault tolerance, long with it
  always_comb begin
    lim = hft_nonzero ? IW'(DIAG1_MS) : IW'(DIAG0_MS); // [RL6]
    r_next = r_reg;
    r_next.strobe = 1'b0;
    r_next.fault = 1'b0;
    r_next.exp = expect_en;
    // readback lags the command, so skip checks right after a change
    if (expect_en != r_reg.exp) begin
      r_next.settle = '0;
    end else if (r_reg.settle != SW'(SETTLE_CYC)) begin
      r_next.settle = r_reg.settle + 1'b1;
    end
    if (ms_tick) begin
      if (r_reg.ms >= lim - 1'b1) begin
        r_next.ms = '0;
        r_next.strobe = 1'b1; // [RL6]
        r_next.fault = (r_reg.settle == SW'(SETTLE_CYC)) &&
                       (fb != expect_en); // [RL7]
      end else begin
        r_next.ms = r_reg.ms + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign strobe = r_reg.strobe;
  assign fault = r_reg.fault;
endmodule

// *** verilog/sto_gate.sv ***
// safe torque off gate: filters, gating, alarms and monitor output
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] pwm passes to the power stage only while both inputs are on
// [RL2] either input off blocks pwm and removes torque
// [RL3] safe state turns off every pwm line, never a subset
// [RL4] an input counts as off only after staying low over 2 ms
// [RL5] input trigger to pwm off takes no more than 30 ms
// [RL6] self-test period under 20 ms, or under 1 h with fault tolerance
// [RL7] test interval plus fault reaction stays below 30 ms; the code keeps it only without fault tolerance (1000 ms test gap with it)
// [RL8] any diagnosed fault forces the safe state
// [RL9] disconnection alarm after either input off over 10 s
// [RL10] separate latched alarm for a damaged gating circuit
// [RL11] monitor on only with both inputs off and no fault, within 5 ms
// [RL12] disconnection timer counts continuous time, restarts when both on
module sto_gate
  import sto_pkg::*;
#(
  parameter int N = PWM_N,
  parameter int FILT = FILT_CYC,
  parameter int MS = MS_CYC,
  parameter int DISC = DISC_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic safety_input_one,
  input wire logic safety_input_two,
  input wire logic gate_feedback,
  input wire logic hft_nonzero,
  input wire logic fault_clear,
  input wire logic [N-1:0] pwm_in,
  output logic [N-1:0] pwm_out,
  output logic gate_enable,
  output logic safe_torque_off,
  output logic stop_monitor_output,
  output logic alarm_safety_disconnect,
  output logic alarm_safety_circuit_fault
);
  localparam int MW = $clog2(MS + 1);
  localparam int DW = $clog2(DISC + 1);
  localparam int LW = $clog2(FILT + 4);
  localparam int TW = $clog2(DIAG1_LIM_MS + 1);

  typedef struct packed {
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy2;
    sto_state_e st;
    logic [N-1:0] pwm;
    logic gate;
    logic sto;
    logic mon;
    logic alm_disc;
    logic alm_flt;
    logic [MW-1:0] ms_cnt;
    logic ms_tick;
    logic [DW-1:0] disc_cnt;
  } sto_gate_s;

  sto_gate_s r_reg;
  sto_gate_s r_next;
  logic on1;
  logic on2;
  logic both_on;
  logic diag_strobe;
  logic diag_fault;

  ////////////////////////////////////////////////////////////////////////
  // per-channel input filters
  sto_filt #(
    .CYC(FILT)
  ) u_filt_one (
    .core_clk(core_clk),
    .rst(rst),
    .raw(r_reg.sy2[SY_ONE]),
    .on(on1)
  );

  sto_filt #(
    .CYC(FILT)
  ) u_filt_two (
    .core_clk(core_clk),
    .rst(rst),
    .raw(r_reg.sy2[SY_TWO]),
    .on(on2)
  );

  // readback test compares the commanded gate with the circuit state
  sto_diag u_diag (
    .core_clk(core_clk),
    .rst(rst),
    .ms_tick(r_reg.ms_tick),
    .hft_nonzero(r_reg.sy2[SY_HFT]),
    .expect_en(r_reg.gate),
    .fb(r_reg.sy2[SY_FB]),
    .strobe(diag_strobe),
    .fault(diag_fault)
  );

  assign both_on = on1 && on2;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_next = r_reg;
    // two-stage synchronisers for the safety input, feedback and strap pins; only the second stage is
    // read anywhere else, so a metastable first stage never spreads
    r_next.sy1 = {hft_nonzero, gate_feedback, safety_input_two,
                  safety_input_one};
    r_next.sy2 = r_reg.sy1;

    // millisecond tick for the slow timers
    r_next.ms_tick = 1'b0;
    if (r_reg.ms_cnt == MW'(MS - 1)) begin
      r_next.ms_cnt = '0;
      r_next.ms_tick = 1'b1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 1'b1;
    end

    // continuous disconnection time, saturating at the alarm point
    if (both_on) begin
      r_next.disc_cnt = '0; // [RL12]
    end else if (r_reg.ms_tick && r_reg.disc_cnt != DW'(DISC)) begin
      r_next.disc_cnt = r_reg.disc_cnt + 1'b1;
    end
    r_next.alm_disc = !both_on && (r_reg.disc_cnt == DW'(DISC)); // [RL9]

    // circuit fault alarm: latched, a new fault wins over the clear
    if (diag_fault) begin
      r_next.alm_flt = 1'b1; // [RL10]
    end else if (fault_clear) begin
      r_next.alm_flt = 1'b0;
    end

    // gate state
    case (r_reg.st)
      ST_RUN: begin
        if (r_next.alm_flt) begin
          r_next.st = ST_FAULT; // [RL8]
        end else if (!both_on) begin
          r_next.st = ST_SAFE; // [RL2]
        end
      end
      ST_SAFE: begin
        if (r_next.alm_flt) begin
          r_next.st = ST_FAULT;
        end else if (both_on) begin
          r_next.st = ST_RUN; // [RL1]
        end
      end
      ST_FAULT: begin
        // leave only once software cleared the alarm
        if (!r_next.alm_flt) begin
          r_next.st = ST_SAFE;
        end
      end
      default: begin
        r_next.st = ST_SAFE;
      end
    endcase

    // outputs follow the next state so blocking costs one cycle
    r_next.gate = (r_next.st == ST_RUN); // [RL5]
    r_next.sto = (r_next.st != ST_RUN);
    r_next.pwm = r_next.gate ? pwm_in : '0; // [RL3]
    r_next.mon = !on1 && !on2 && !r_next.alm_flt &&
                 (r_next.st != ST_FAULT); // [RL11]
  end

  // reset lands in the safe state with every pwm line low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= ST_SAFE;
      r_reg.sto <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pwm_out = r_reg.pwm;
  assign gate_enable = r_reg.gate;
  assign safe_torque_off = r_reg.sto;
  assign stop_monitor_output = r_reg.mon;
  assign alarm_safety_disconnect = r_reg.alm_disc;
  assign alarm_safety_circuit_fault = r_reg.alm_flt;

  ////////////////////////////////////////////////////////////////////////
  // helper counters read only by the checks below; the low counters stop
  // just past the filter time, which is all the response checks need
  logic [LW-1:0] low1;
  logic [LW-1:0] low2;
  logic [TW-1:0] since_ms;
  logic hft_seen;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low1 <= '0;
      low2 <= '0;
      since_ms <= '0;
      hft_seen <= 1'b0;
    end else begin
      if (r_reg.sy2[SY_ONE]) begin
        low1 <= '0;
      end else if (low1 != LW'(FILT + 3)) begin
        low1 <= low1 + 1'b1;
      end
      if (r_reg.sy2[SY_TWO]) begin
        low2 <= '0;
      end else if (low2 != LW'(FILT + 3)) begin
        low2 <= low2 + 1'b1;
      end
      // ms ticks since the last readback test
      if (diag_strobe) begin
        since_ms <= '0;
      end else if (r_reg.ms_tick) begin
        since_ms <= since_ms + 1'b1;
      end
      // a strap that was high during the current test gap still allows
      // the long gap, so dropping it cannot trip the short limit
      if (diag_strobe) begin
        hft_seen <= r_reg.sy2[SY_HFT];
      end else if (r_reg.sy2[SY_HFT]) begin
        hft_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  pwm_pass_a: assert property ( // [RL1]
    gate_enable |-> pwm_out == $past(pwm_in))
    else $error("pwm not passed while enabled");

  pwm_block_a: assert property ( // [RL2]
    !(on1 && on2) |=> !gate_enable && safe_torque_off)
    else $error("pwm not blocked with an input off");

  all_off_a: assert property ( // [RL3]
    !gate_enable |-> pwm_out == '0)
    else $error("pwm line active in safe state");

  filt_time_a: assert property ( // [RL4]
    $fell(on1) |-> low1 >= LW'(FILT + 1))
    else $error("input one dropped before filter time");

  resp_bound_a: assert property ( // [RL5]
    low1 == LW'(FILT + 3) |-> !gate_enable)
    else $error("response time exceeded");

  diag_period_a: assert property ( // [RL6]
    since_ms < (hft_seen || r_reg.sy2[SY_HFT] ? TW'(DIAG1_LIM_MS) :
                TW'(DIAG0_LIM_MS)))
    else $error("diagnostic interval too long");

  // a failed test blocks the gate two cycles later, far inside one tick,
  // so a short test gap leaves the whole reaction budget unused
  test_react_a: assert property ( // [RL7]
    !hft_seen && !r_reg.sy2[SY_HFT] |-> since_ms < TW'(RESP_MS - 1))
    else $error("test gap leaves no room for fault reaction");

  filt_two_a: assert property ( // [RL4]
    $fell(on2) |-> low2 >= LW'(FILT + 1))
    else $error("input two dropped before filter time");

  resp_two_a: assert property ( // [RL5]
    low2 == LW'(FILT + 3) |-> !gate_enable)
    else $error("response time exceeded on input two");

  run_start_a: assert property ( // [RL1]
    $rose(gate_enable) |-> $past(on1) && $past(on2))
    else $error("gate opened without both inputs on");

  mon_on_a: assert property ( // [RL11]
    !on1 && !on2 ##1 !alarm_safety_circuit_fault |-> stop_monitor_output)
    else $error("monitor late with both inputs off");

  flt_clear_a: assert property ( // [RL10]
    alarm_safety_circuit_fault && fault_clear && !diag_fault
      |=> !alarm_safety_circuit_fault)
    else $error("circuit fault alarm not cleared");

  fault_safe_a: assert property ( // [RL8]
    diag_fault |=> !gate_enable && alarm_safety_circuit_fault
                   && pwm_out == '0)
    else $error("fault did not force safe state");

  disc_alarm_a: assert property ( // [RL9]
    $rose(alarm_safety_disconnect) |-> !($past(on1) && $past(on2))
      && $past(r_reg.disc_cnt) == DW'(DISC))
    else $error("disconnect alarm at wrong time");

  disc_restart_a: assert property ( // [RL12]
    on1 && on2 |=> r_reg.disc_cnt == '0 && !alarm_safety_disconnect)
    else $error("disconnect timer not restarted");

  flt_hold_a: assert property ( // [RL10]
    alarm_safety_circuit_fault && !fault_clear
      |=> alarm_safety_circuit_fault)
    else $error("circuit fault alarm dropped");

  mon_cond_a: assert property ( // [RL11]
    stop_monitor_output |-> !$past(on1) && !$past(on2)
      && !alarm_safety_circuit_fault)
    else $error("monitor on with an input on or a fault");

  run_cov: cover property (gate_enable ##1 !gate_enable);
  fault_cov: cover property ($rose(alarm_safety_circuit_fault));
  disc_cov: cover property ($rose(alarm_safety_disconnect));
  mon_cov: cover property ($rose(stop_monitor_output));
  hft_cov: cover property (diag_strobe && r_reg.sy2[SY_HFT]);
endmodule

// *** bench/sto_switch.sv ***
// model of the external safety switch that feeds both safety channels
`timescale 1ns/1ps
module sto_switch (
  input wire logic close_one,
  input wire logic close_two,
  output logic ch_one,
  output logic ch_two
);
  // an open contact leaves the input to its pull-down, so it reads low
  assign ch_one = close_one;
  assign ch_two = close_two;
endmodule

// *** bench/tb_top.sv ***
// self-checking testbench for the safe torque off gate
`timescale 1ns/1ps
module tb_top
  import sto_pkg::*;
;
  // shortened counts: filter cycles, cycles per ms tick, alarm ms
  localparam int FI = 20;
  localparam int MSC = 10;
  localparam int DI = 5;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic close_one = 1'b0;
  logic close_two = 1'b0;
  logic fb_break = 1'b0;
  logic hft_nonzero = 1'b0;
  logic fault_clear = 1'b0;
  logic gate_feedback = 1'b0;
  logic [PWM_N-1:0] pwm_in = '0;
  logic [PWM_N-1:0] pwm_out;
  logic s_one, s_two, gate_enable, safe_torque_off, stop_monitor_output;
  logic alarm_safety_disconnect, alarm_safety_circuit_fault;
  int n_errors = 0;
  int n_compared = 0;

  always #12.5 core_clk = ~core_clk;

  // readback of the blocking circuit; a break models a damaged circuit
  always @(negedge core_clk) gate_feedback <= gate_enable ^ fb_break;

  sto_switch i_sto_switch (.close_one(close_one), .close_two(close_two),
    .ch_one(s_one), .ch_two(s_two));

  sto_gate #(.N(PWM_N), .FILT(FI), .MS(MSC), .DISC(DI)) i_sto_gate (
    .core_clk(core_clk), .rst(rst), .safety_input_one(s_one),
    .safety_input_two(s_two), .gate_feedback(gate_feedback),
    .hft_nonzero(hft_nonzero), .fault_clear(fault_clear), .pwm_in(pwm_in),
    .pwm_out(pwm_out), .gate_enable(gate_enable),
    .safe_torque_off(safe_torque_off),
    .stop_monitor_output(stop_monitor_output),
    .alarm_safety_disconnect(alarm_safety_disconnect),
    .alarm_safety_circuit_fault(alarm_safety_circuit_fault));

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return gate_enable;
      1: return stop_monitor_output;
      2: return alarm_safety_disconnect;
      default: return alarm_safety_circuit_fault;
    endcase
  endfunction

  // bounded wait until output k reads v
  task automatic wait_for(input string nm, input int k, input logic v,
                          input int lim);
    int t;
    t = 0;
    n_compared++;
    while (sig(k) !== v) begin
      @(negedge core_clk);
      t++;
      if (t > lim) begin
        n_errors++;
        $display("[ERR] %s expected %b seen timeout", nm, v);
        tally_and_finish();
      end
    end
  endtask

  // output k must keep value v for n cycles
  task automatic hold(input string nm, input int k, input logic v,
                      input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if (sig(k) !== v) begin
        chk(nm, {7'h0, v}, {7'h0, sig(k)});
        return;
      end
    end
    chk(nm, {7'h0, v}, {7'h0, sig(k)});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_run();
    logic [PWM_N-1:0] pat [3];
    pat = '{6'h3f, 6'h15, 6'h2a};
    wait_for("gate on", 0, 1'b1, FI + 10);
    chk("sto off", 8'h0, {7'h0, safe_torque_off});
    foreach (pat[i]) begin
      pwm_in = pat[i];
      @(negedge core_clk);
      chk("pwm pass", {2'h0, pat[i]}, {2'h0, pwm_out});
    end
    $display("test run done");
  endtask

  task automatic t_stop();
    // a drop shorter than the filter must change nothing
    close_one = 1'b0;
    repeat (FI - 2) @(negedge core_clk);
    close_one = 1'b1;
    hold("short drop", 0, 1'b1, 2 * FI);
    close_one = 1'b0;
    hold("filter time", 0, 1'b1, FI);
    wait_for("gate off", 0, 1'b0, RESP_MS * MSC);
    @(negedge core_clk);
    chk("all pwm off", 8'h0, {2'h0, pwm_out});
    chk("sto on", 8'h1, {7'h0, safe_torque_off});
    chk("monitor one off", 8'h0, {7'h0, stop_monitor_output});
    close_two = 1'b0;
    wait_for("monitor on", 1, 1'b1, MON_MS * MSC);
    close_one = 1'b1;
    close_two = 1'b1;
    wait_for("monitor off", 1, 1'b0, FI + 10);
    wait_for("gate back", 0, 1'b1, FI + 10);
    $display("test stop done");
  endtask

  task automatic t_disc();
    // two short gaps must not add up to the alarm time
    for (int i = 0; i < 2; i++) begin
      close_one = 1'b0;
      hold("gap no alarm", 2, 1'b0, 30);
      close_one = 1'b1;
      hold("gap no alarm", 2, 1'b0, 80);
    end
    close_two = 1'b0;
    hold("alarm early", 2, 1'b0, FI + (DI - 1) * MSC);
    chk("gate off two", 8'h0, {7'h0, gate_enable});
    wait_for("alarm on", 2, 1'b1, 60);
    close_two = 1'b1;
    wait_for("alarm off", 2, 1'b0, FI + 10);
    wait_for("gate back", 0, 1'b1, FI + 10);
    $display("test disconnect done");
  endtask

  task automatic t_diag(input logic hft, input int lim);
    hft_nonzero = hft;
    fb_break = 1'b1;
    pwm_in = '1;
    wait_for("circuit fault", 3, 1'b1, lim);
    @(negedge core_clk);
    chk("fault gate", 8'h0, {7'h0, gate_enable});
    chk("fault pwm", 8'h0, {2'h0, pwm_out});
    chk("fault sto", 8'h1, {7'h0, safe_torque_off});
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
    repeat (lim) @(negedge core_clk);
    chk("clear refused", 8'h1, {7'h0, alarm_safety_circuit_fault});
    fb_break = 1'b0;
    repeat (lim) @(negedge core_clk);
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
    wait_for("fault cleared", 3, 1'b0, 5);
    wait_for("gate back", 0, 1'b1, FI + 10);
    $display("test diagnostics done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge core_clk);
    chk("reset pwm", 8'h0, {2'h0, pwm_out});
    chk("reset gate", 8'h0, {7'h0, gate_enable});
    chk("reset sto", 8'h1, {7'h0, safe_torque_off});
    close_one = 1'b1;
    close_two = 1'b1;
    rst = 1'b0;
    t_run();
    t_stop();
    t_disc();
    t_diag(1'b0, DIAG0_LIM_MS * MSC);
    t_diag(1'b1, DIAG1_MS * MSC + 100);
    tally_and_finish();
  end
endmodule
